// [verilog/pdfl_flag_logic.sv]
`timescale 1ns/1ns
`default_nettype none
module pdfl_flag_logic (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic tx_desc_valid_in,
    input wire pdfl_pkg::pdfl_desc_t tx_desc_in,
    output logic tx_desc_ready_out,
    input wire logic tx_sent_in,
    input wire logic tx_teardown_in,
    input wire logic tx_restart_in,
    output logic tx_append_crc_out,
    output logic [15:0] tx_wire_len_out,
    output logic [31:0] tx_next_addr_out,
    output logic tx_halted_out,
    output logic tx_teardown_done_out,
    input wire logic rx_desc_valid_in,
    input wire pdfl_pkg::pdfl_desc_t rx_desc_in,
    output logic rx_desc_ready_out,
    input wire logic rx_done_in,
    input wire pdfl_pkg::pdfl_rx_result_t rx_result_in,
    input wire logic rx_restart_in,
    output logic [31:0] rx_write_addr_out,
    output logic [31:0] rx_next_addr_out,
    output logic rx_halted_out,
    output logic wb_valid_out,
    input wire logic wb_ready_in,
    output var pdfl_pkg::pdfl_wb_t wb_out
);
    // =================================================================
    // Declarations
    // =================================================================
    pdfl_pkg::pdfl_tx_state_t tx_state;
    pdfl_pkg::pdfl_rx_state_t rx_state;
    pdfl_pkg::pdfl_desc_t tx_cur;
    pdfl_pkg::pdfl_desc_t tx_sop;
    pdfl_pkg::pdfl_desc_t rx_cur;
    pdfl_pkg::pdfl_rx_result_t rx_res;
    pdfl_pkg::pdfl_wb_t tx_wb;
    pdfl_pkg::pdfl_wb_t rx_wb;
    pdfl_pkg::pdfl_wb_t push_data;
    pdfl_pkg::pdfl_wb_t buf_q [pdfl_pkg::BUF_DEPTH];
    logic [pdfl_pkg::BUF_DEPTH-1:0] buf_v;
    logic tx_qend;
    logic tx_single;
    logic tx_abort;
    logic td_pend;
    logic rx_link_null;
    logic tx_push;
    logic rx_push;
    logic push_ready;
    logic tx_acc;
    logic rx_acc;
    logic pop;

    // =================================================================
    // Write-back arbitration
    // =================================================================
    // Transmit write-backs win; receive simply waits, nothing is lost.
    assign tx_push = (tx_state == pdfl_pkg::T_WB_LAST) ||
                     (tx_state == pdfl_pkg::T_WB_FIRST);
    assign rx_push = (rx_state == pdfl_pkg::R_WB) && !tx_push;
    assign push_ready = !buf_v[1];
    assign tx_acc = tx_push && push_ready;
    assign rx_acc = rx_push && push_ready;
    assign pop = buf_v[0] && wb_ready_in;
    assign push_data = tx_push ? tx_wb : rx_wb;

    // Only word 3 is ever written, so link and buffer words stay intact.
    always_comb begin
        tx_wb = '0;
        if (tx_state == pdfl_pkg::T_WB_LAST) begin
            tx_wb.addr = tx_cur.addr + pdfl_pkg::WORD3_OFFSET;
            tx_wb.word3 = tx_cur.word3;
            tx_wb.word3[pdfl_pkg::QEND_BIT] = tx_qend;
        end else begin
            tx_wb.addr = tx_sop.addr + pdfl_pkg::WORD3_OFFSET;
            tx_wb.word3 = tx_sop.word3;
            // Flags land in the same write that releases it.
            tx_wb.word3[pdfl_pkg::HOLDS_BIT] = 1'b0;
            tx_wb.word3[pdfl_pkg::TDONE_BIT] = tx_abort;
            tx_wb.word3[pdfl_pkg::QEND_BIT] = tx_single && tx_qend;
        end
    end

    // Receive word 3: flags, status byte and received length.
    always_comb begin
        rx_wb.addr = rx_cur.addr + pdfl_pkg::WORD3_OFFSET;
        rx_wb.word3 = rx_cur.word3;
        rx_wb.word3[pdfl_pkg::LAST_BIT] = rx_res.last;
        rx_wb.word3[pdfl_pkg::HOLDS_BIT] = !rx_res.last;
        rx_wb.word3[pdfl_pkg::QEND_BIT] = rx_link_null;
        rx_wb.word3[pdfl_pkg::STAT_MSB:pdfl_pkg::STAT_LSB] =
            rx_res.status;
        rx_wb.word3[15:0] = rx_res.len;
    end

    // =================================================================
    // Two-entry write-back buffer
    // =================================================================
    // Entry 0 drives the port directly; entry 1 catches a word while
    // memory stalls, so a stalled write waits as long as the stall lasts, never losing data.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buf_v <= '0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else if (pop || !buf_v[0]) begin
            if (buf_v[1]) begin
                buf_q[0] <= buf_q[1];
                buf_v <= 2'b01;
            end else begin
                buf_q[0] <= push_data;
                buf_v <= {1'b0, tx_acc || rx_acc};
            end
        end else if (tx_acc || rx_acc) begin
            // Only an accepted push may land, or a full entry 1 is lost.
            buf_q[1] <= push_data;
            buf_v[1] <= 1'b1;
        end
    end

    assign wb_valid_out = buf_v[0];
    assign wb_out = buf_q[0];

    // =================================================================
    // Teardown request
    // =================================================================
    // A new request in the cycle it is consumed stays pending.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            td_pend <= 1'b0;
        end else if (tx_teardown_in) begin
            td_pend <= 1'b1;
        end else if ((tx_state == pdfl_pkg::T_IDLE && tx_desc_valid_in &&
                      tx_desc_in.word3[pdfl_pkg::FIRST_BIT]) ||
                     tx_state == pdfl_pkg::T_HALT) begin
            td_pend <= 1'b0;
        end
    end

    // =================================================================
    // Transmit descriptor sequencing
    // =================================================================
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_state <= pdfl_pkg::T_IDLE;
            tx_cur <= '0;
            tx_sop <= '0;
            tx_qend <= 1'b0;
            tx_single <= 1'b0;
            tx_abort <= 1'b0;
            tx_next_addr_out <= pdfl_pkg::ADDR_RESET;
        end else begin
            case (tx_state)
                pdfl_pkg::T_IDLE: begin
                    if (tx_desc_valid_in) begin
                        tx_cur <= tx_desc_in;
                        tx_qend <= 1'b0;
                        if (tx_desc_in.word3[pdfl_pkg::FIRST_BIT]) begin
                            tx_sop <= tx_desc_in;
                            tx_abort <= td_pend;
                            tx_single <= td_pend ||
                                tx_desc_in.word3[pdfl_pkg::LAST_BIT];
                            // Aborted packet is never sent.
                            tx_state <= td_pend ? pdfl_pkg::T_WB_FIRST :
                                pdfl_pkg::T_SEND;
                        end else begin
                            tx_state <= pdfl_pkg::T_SEND;
                        end
                    end
                end
                pdfl_pkg::T_SEND: begin
                    if (tx_sent_in) begin
                        tx_next_addr_out <= tx_cur.link;
                        if (tx_cur.word3[pdfl_pkg::LAST_BIT]) begin
                            // Null link after a last buffer ends queue.
                            tx_qend <= (tx_cur.link ==
                                        pdfl_pkg::NULL_LINK);
                            tx_state <= tx_single ? pdfl_pkg::T_WB_FIRST :
                                pdfl_pkg::T_WB_LAST;
                        end else begin
                            tx_state <= pdfl_pkg::T_IDLE;
                        end
                    end
                end
                pdfl_pkg::T_WB_LAST: begin
                    if (tx_acc) begin
                        tx_state <= pdfl_pkg::T_WB_FIRST;
                    end
                end
                pdfl_pkg::T_WB_FIRST: begin
                    if (tx_acc) begin
                        // Teardown stops the walk: later ones untouched.
                        tx_state <= (tx_abort || tx_qend) ?
                            pdfl_pkg::T_HALT :
                            pdfl_pkg::T_IDLE;
                    end
                end
                pdfl_pkg::T_HALT: begin
                    if (tx_restart_in) begin
                        tx_state <= pdfl_pkg::T_IDLE;
                        tx_abort <= 1'b0;
                    end
                end
                default: tx_state <= pdfl_pkg::T_IDLE;
            endcase
        end
    end

    // Frame check handling follows the first descriptor of the packet.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_append_crc_out <= 1'b0;
            tx_wire_len_out <= pdfl_pkg::LEN_RESET;
        end else if (tx_state == pdfl_pkg::T_IDLE && tx_desc_valid_in &&
                     tx_desc_in.word3[pdfl_pkg::FIRST_BIT]) begin
            tx_append_crc_out <=
                !tx_desc_in.word3[pdfl_pkg::CRCSUP_BIT];
            // Lengths exclude a generated CRC, so add it on the wire.
            tx_wire_len_out <= tx_desc_in.word3[pdfl_pkg::CRCSUP_BIT] ?
                tx_desc_in.word3[15:0] :
                tx_desc_in.word3[15:0] + pdfl_pkg::CRC_BYTES;
        end
    end

    // Teardown done pulse: on abort write, or at once if already halted.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_teardown_done_out <= 1'b0;
        end else begin
            tx_teardown_done_out <= (tx_acc && tx_abort &&
                tx_state == pdfl_pkg::T_WB_FIRST) ||
                (td_pend && tx_state == pdfl_pkg::T_HALT);
        end
    end

    // One-hot state bits feed the ports directly, with no decode.
    assign tx_desc_ready_out = tx_state[0];
    assign tx_halted_out = tx_state[4];

    // =================================================================
    // Receive descriptor sequencing
    // =================================================================
    // The link is sampled once at fetch; a later append is missed and
    // the channel halts, which software sees as queue end.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_state <= pdfl_pkg::R_IDLE;
            rx_cur <= '0;
            rx_res <= '0;
            rx_link_null <= 1'b0;
            rx_write_addr_out <= pdfl_pkg::ADDR_RESET;
            rx_next_addr_out <= pdfl_pkg::ADDR_RESET;
        end else begin
            case (rx_state)
                pdfl_pkg::R_IDLE: begin
                    if (rx_desc_valid_in) begin
                        rx_cur <= rx_desc_in;
                        rx_link_null <= (rx_desc_in.link ==
                                         pdfl_pkg::NULL_LINK);
                        rx_next_addr_out <= rx_desc_in.link;
                        // Any byte address is accepted as it stands.
                        rx_write_addr_out <= rx_desc_in.buf_ptr +
                            {16'h0000, rx_desc_in.word2[31:16]};
                        rx_state <= pdfl_pkg::R_FILL;
                    end
                end
                pdfl_pkg::R_FILL: begin
                    if (rx_done_in) begin
                        rx_res <= rx_result_in;
                        rx_state <= pdfl_pkg::R_WB;
                    end
                end
                pdfl_pkg::R_WB: begin
                    if (rx_acc) begin
                        rx_state <= rx_link_null ? pdfl_pkg::R_HALT :
                            pdfl_pkg::R_IDLE;
                    end
                end
                pdfl_pkg::R_HALT: begin
                    if (rx_restart_in) begin
                        rx_state <= pdfl_pkg::R_IDLE;
                    end
                end
                default: rx_state <= pdfl_pkg::R_IDLE;
            endcase
        end
    end

    // One-hot state bits feed the ports directly, with no decode.
    assign rx_desc_ready_out = rx_state[0];
    assign rx_halted_out = rx_state[3];

    // =================================================================
    // Assertions
    // =================================================================
    sequence s_tx_sop_fetch;
        tx_desc_ready_out && tx_desc_valid_in &&
        tx_desc_in.word3[pdfl_pkg::FIRST_BIT];
    endsequence
    sequence s_tx_final_wb;
        tx_acc && tx_state == pdfl_pkg::T_WB_FIRST;
    endsequence

    property p_qend_halt;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_tx_final_wb ##0 tx_wb.word3[pdfl_pkg::QEND_BIT] |=> tx_halted_out;
    endproperty
    a_qend_halt: assert property (p_qend_halt)
        else $error("queue end write did not halt transmit");

    property p_qend_last_only;
        @(posedge clk_in) disable iff (!rst_n_in)
        tx_push && push_data.word3[pdfl_pkg::QEND_BIT] |->
        tx_cur.word3[pdfl_pkg::LAST_BIT] && tx_cur.link == 32'h0;
    endproperty
    a_qend_last_only: assert property (p_qend_last_only)
        else $error("queue end set on a non-last descriptor");

    property p_td_first;
        @(posedge clk_in) disable iff (!rst_n_in)
        tx_push && push_data.word3[pdfl_pkg::TDONE_BIT] |->
        push_data.word3[pdfl_pkg::FIRST_BIT] &&
        !push_data.word3[pdfl_pkg::HOLDS_BIT];
    endproperty
    a_td_first: assert property (p_td_first)
        else $error("teardown flag outside a released first descriptor");

    property p_td_stop;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(tx_teardown_done_out) && !$past(tx_restart_in) |->
        !tx_desc_ready_out;
    endproperty
    a_td_stop: assert property (p_td_stop)
        else $error("descriptors taken after teardown");

    property p_crc_mode;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_tx_sop_fetch ##1 1 |->
        tx_append_crc_out == !$past(tx_desc_in.word3[pdfl_pkg::CRCSUP_BIT]) &&
        tx_wire_len_out == $past(tx_desc_in.word3[15:0]) +
            (tx_append_crc_out ? 16'h0004 : 16'h0000);
    endproperty
    a_crc_mode: assert property (p_crc_mode)
        else $error("crc mode or wire length wrong");

    property p_rx_halt;
        @(posedge clk_in) disable iff (!rst_n_in)
        rx_acc && rx_link_null |=> rx_halted_out [*1] ##0 !rx_desc_ready_out;
    endproperty
    a_rx_halt: assert property (p_rx_halt)
        else $error("receive did not halt on null link");

    property p_wb_word3;
        @(posedge clk_in) disable iff (!rst_n_in)
        tx_acc || rx_acc |->
        push_data.addr - (rx_acc ? rx_cur.addr :
            tx_state == pdfl_pkg::T_WB_LAST ? tx_cur.addr : tx_sop.addr) ==
            32'h0000000c;
    endproperty
    a_wb_word3: assert property (p_wb_word3)
        else $error("write-back outside word 3");

    property p_rx_addr;
        @(posedge clk_in) disable iff (!rst_n_in)
        rx_desc_ready_out && rx_desc_valid_in |=>
        rx_write_addr_out == $past(rx_desc_in.buf_ptr) +
            {16'h0000, $past(rx_desc_in.word2[31:16])};
    endproperty
    a_rx_addr: assert property (p_rx_addr)
        else $error("receive write address not buffer plus offset");

    property p_rx_status;
        @(posedge clk_in) disable iff (!rst_n_in)
        rx_acc |-> push_data.word3[23:16] == rx_res.status;
    endproperty
    a_rx_status: assert property (p_rx_status)
        else $error("receive status bits misplaced");

    property p_holds_after_last;
        @(posedge clk_in) disable iff (!rst_n_in)
        tx_acc && tx_state == pdfl_pkg::T_WB_LAST |=>
        tx_state == pdfl_pkg::T_WB_FIRST;
    endproperty
    a_holds_after_last: assert property (p_holds_after_last)
        else $error("first descriptor not released after last");
endmodule // pdfl_flag_logic
`default_nettype wire

// [verilog/pdfl_pkg.sv]
`default_nettype none
// =====================================================================
// Shared constants and carriers of the descriptor flag logic.
// =====================================================================
package pdfl_pkg;
    // Flag positions in descriptor word 3.
    localparam int FIRST_BIT = 31;
    localparam int LAST_BIT = 30;
    localparam int HOLDS_BIT = 29;
    localparam int QEND_BIT = 28;
    localparam int TDONE_BIT = 27;
    localparam int CRCSUP_BIT = 26;
    // Receive status byte sits in bits 23..16 of word 3.
    localparam int STAT_LSB = 16;
    localparam int STAT_MSB = 23;
    // Byte offset of word 3 inside a four-word descriptor.
    localparam logic [31:0] WORD3_OFFSET = 32'h0000000c;
    localparam logic [15:0] CRC_BYTES = 16'h0004;
    localparam logic [31:0] NULL_LINK = 32'h00000000;
    localparam logic [31:0] ADDR_RESET = 32'h00000000;
    localparam logic [15:0] LEN_RESET = 16'h0000;
    localparam int BUF_DEPTH = 2;

    // Descriptor as fetched: its own address and its four words.
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] link;
        logic [31:0] buf_ptr;
        logic [31:0] word2;
        logic [31:0] word3;
    } pdfl_desc_t;

    // One write-back of word 3 to system memory.
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] word3;
    } pdfl_wb_t;

    // Receive outcome; status[7] is fragment down to status[0] miss.
    typedef struct packed {
        logic last;
        logic [7:0] status;
        logic [15:0] len;
    } pdfl_rx_result_t;

    typedef enum logic [4:0] {
        T_IDLE = 5'h01,
        T_SEND = 5'h02,
        T_WB_LAST = 5'h04,
        T_WB_FIRST = 5'h08,
        T_HALT = 5'h10
    } pdfl_tx_state_t;

    typedef enum logic [3:0] {
        R_IDLE = 4'h1,
        R_FILL = 4'h2,
        R_WB = 4'h4,
        R_HALT = 4'h8
    } pdfl_rx_state_t;
endpackage
`default_nettype wire

// [tb/pdfl_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Host memory model: takes descriptor write-backs and keeps them.
module pdfl_host_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic stall_in,
    input wire logic wb_valid_in,
    input wire pdfl_pkg::pdfl_wb_t wb_in,
    output logic wb_ready_out
);
    pdfl_pkg::pdfl_wb_t log[$];

    // Ready moves off the sampling edge so a stall never races the accept.
    initial wb_ready_out = 1'b0;
    always @(negedge clk_in) begin
        wb_ready_out <= rst_n_in && !stall_in;
    end

    // Each accepted entry is one word 3 store of a four-word descriptor.
    always @(posedge clk_in) begin
        if (rst_n_in && wb_valid_in && wb_ready_out) begin
            log.push_back(wb_in);
        end
    end
endmodule // pdfl_host_model
`default_nettype wire

// [tb/packet_descriptor_flag_logic_test.sv]
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Self-checking bench for the descriptor flag logic.
module packet_descriptor_flag_logic_test;
    localparam logic [31:0] F = 32'h1 << pdfl_pkg::FIRST_BIT;
    localparam logic [31:0] L = 32'h1 << pdfl_pkg::LAST_BIT;
    localparam logic [31:0] H = 32'h1 << pdfl_pkg::HOLDS_BIT;
    localparam logic [31:0] Q = 32'h1 << pdfl_pkg::QEND_BIT;
    localparam logic [31:0] T = 32'h1 << pdfl_pkg::TDONE_BIT;
    localparam logic [31:0] C = 32'h1 << pdfl_pkg::CRCSUP_BIT;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic tx_v = 1'b0, tx_sent = 1'b0, tx_td = 1'b0, tx_rs = 1'b0;
    logic rx_v = 1'b0, rx_done = 1'b0, rx_rs = 1'b0, stall = 1'b0;
    pdfl_pkg::pdfl_desc_t tx_d = '0, rx_d = '0;
    pdfl_pkg::pdfl_rx_result_t rx_res = '0;
    logic tx_rdy, tx_crc, tx_halt, tx_tdone, rx_rdy, rx_halt, wb_v, wb_r;
    logic [15:0] tx_len;
    logic [31:0] tx_nxt, rx_wa, rx_nxt;
    pdfl_pkg::pdfl_wb_t wb;
    int bad_count = 0, compares = 0, tdone = 0, base;

    pdfl_flag_logic dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .tx_desc_valid_in(tx_v), .tx_desc_in(tx_d),
        .tx_desc_ready_out(tx_rdy), .tx_sent_in(tx_sent),
        .tx_teardown_in(tx_td), .tx_restart_in(tx_rs),
        .tx_append_crc_out(tx_crc), .tx_wire_len_out(tx_len),
        .tx_next_addr_out(tx_nxt), .tx_halted_out(tx_halt),
        .tx_teardown_done_out(tx_tdone), .rx_desc_valid_in(rx_v),
        .rx_desc_in(rx_d), .rx_desc_ready_out(rx_rdy),
        .rx_done_in(rx_done), .rx_result_in(rx_res),
        .rx_restart_in(rx_rs), .rx_write_addr_out(rx_wa),
        .rx_next_addr_out(rx_nxt), .rx_halted_out(rx_halt),
        .wb_valid_out(wb_v), .wb_ready_in(wb_r), .wb_out(wb));
    pdfl_host_model host (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .stall_in(stall), .wb_valid_in(wb_v), .wb_in(wb),
        .wb_ready_out(wb_r));

    // Clock, and a count of done pulses seen mid-cycle where they settle.
    initial forever #2 clk_in = ~clk_in;
    always @(negedge clk_in) begin
        if (tx_tdone === 1'b1) tdone++;
    end

    // =================================================================
    // Shared tasks.
    task automatic chk(input string n, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic pulse(input int k);
        @(negedge clk_in);
        case (k)
            0: tx_sent = 1'b1;
            1: tx_td = 1'b1;
            2: tx_rs = 1'b1;
            3: rx_done = 1'b1;
            default: rx_rs = 1'b1;
        endcase
        @(negedge clk_in);
        {tx_sent, tx_td, tx_rs, rx_done, rx_rs} = '0;
    endtask

    // Valid and data hold until the edge that sees ready high.
    task automatic offer(input bit rx, input pdfl_pkg::pdfl_desc_t d);
        int n;
        n = 0;
        @(negedge clk_in);
        if (rx) {rx_v, rx_d} = {1'b1, d};
        else {tx_v, tx_d} = {1'b1, d};
        while ((rx ? rx_rdy : tx_rdy) !== 1'b1 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        chk("desc_taken", n < 40, 1);
        @(negedge clk_in);
        {rx_v, tx_v} = '0;
    endtask

    // A descriptor offered while halted must stay untaken and unwritten.
    task automatic refuse(input bit rx, input pdfl_pkg::pdfl_desc_t d);
        @(negedge clk_in);
        if (rx) {rx_v, rx_d} = {1'b1, d};
        else {tx_v, tx_d} = {1'b1, d};
        repeat (6) @(negedge clk_in);
        chk("refused_ready", rx ? rx_rdy : tx_rdy, 0);
        chk("refused_write", host.log.size(), base + 1);
        {rx_v, tx_v} = '0;
    endtask

    task automatic wait_wb(input int n);
        int k;
        k = 0;
        while (host.log.size() < n && k < 60) begin
            @(negedge clk_in);
            k++;
        end
        repeat (2) @(negedge clk_in);
        chk("wb_count", host.log.size(), n);
    endtask

    // =================================================================
    // Scenarios.
    // Host queues descriptors with the queue end flag clear.
    task automatic t_single();
        base = host.log.size();
        offer(0, '{32'h100, 32'h0, 32'h2000, 32'h40,
            F | L | H | 32'h40});
        chk("append_crc", tx_crc, 1);
        chk("wire_len", tx_len, 32'h44);
        pulse(0);
        wait_wb(base + 1);
        chk("wb_addr", host.log[base].addr, 32'h10c);
        chk("wb_w3", host.log[base].word3, F | L | Q | 32'h40);
        chk("tx_halt", tx_halt, 1);
        pulse(2);
        chk("tx_run", tx_halt, 0);
    endtask

    // Two buffers, stalled host: last is stored before first.
    task automatic t_chain();
        base = host.log.size();
        stall = 1'b1;
        offer(0, '{32'h200, 32'h300, 32'h2100, 32'h30,
            F | H | C | 32'h48});
        chk("append_crc", tx_crc, 0);
        chk("wire_len", tx_len, 32'h48);
        pulse(0);
        offer(0, '{32'h300, 32'h400, 32'h2200, 32'h18, L});
        pulse(0);
        repeat (6) @(negedge clk_in);
        chk("wb_held", wb_v, 1);
        stall = 1'b0;
        wait_wb(base + 2);
        chk("wb_addr0", host.log[base].addr, 32'h30c);
        chk("wb_w3_0", host.log[base].word3, L);
        chk("wb_addr1", host.log[base + 1].addr, 32'h20c);
        chk("wb_w3_1", host.log[base + 1].word3, F | C | 32'h48);
        chk("tx_next", tx_nxt, 32'h400);
        chk("tx_halt", tx_halt, 0);
    endtask

    task automatic t_teardown();
        base = host.log.size();
        pulse(1);
        offer(0, '{32'h600, 32'h700, 32'h2300, 32'h10, F | L | H | 32'h10});
        wait_wb(base + 1);
        chk("td_w3", host.log[base].word3 & (T | H), T);
        chk("td_pulse", tdone, 1);
        chk("td_halt", tx_halt, 1);
        refuse(0, '{32'h700, 32'h0, 32'h2400, 32'h10, F | L | H | 32'h10});
        pulse(1);
        repeat (2) @(negedge clk_in);
        chk("td_pulse2", tdone, 2);
        chk("td_nowrite", host.log.size(), base + 1);
        pulse(2);
    endtask

    // Odd buffer address plus offset; null link halts the channel.
    task automatic t_rx();
        base = host.log.size();
        // Link is set before queuing and left alone while active.
        offer(1, '{32'h500, 32'h0, 32'h3001, 32'h00030080,
            H});
        chk("rx_addr", rx_wa, 32'h3004);
        chk("rx_next", rx_nxt, 32'h0);
        rx_res = '{1'b1, 8'ha5, 16'h0040};
        pulse(3);
        wait_wb(base + 1);
        chk("rx_wb_addr", host.log[base].addr, 32'h50c);
        chk("rx_w3", host.log[base].word3 & (L | H | Q | 32'h00ff0000),
            L | Q | 32'h00a50000);
        chk("rx_halt", rx_halt, 1);
        refuse(1, '{32'h800, 32'h0, 32'h3100, 32'h40, H});
        pulse(4);
        chk("rx_run", rx_halt, 0);
    endtask

    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Watchdog: the tests take well under a thousand cycles.
    initial begin
        #(5000 * 4);
        bad_count++;
        summarize();
    end

    // Reset for three cycles, then each scenario in turn.
    initial begin
        repeat (3) @(negedge clk_in);
        chk("tx_ready_rst", tx_rdy, 1);
        chk("rx_ready_rst", rx_rdy, 1);
        chk("wb_valid_rst", wb_v, 0);
        rst_n_in = 1'b1;
        t_single();
        t_chain();
        t_teardown();
        t_rx();
        summarize();
    end
endmodule // packet_descriptor_flag_logic_test
`default_nettype wire
